// File: logic/rxpi_top.sv
// rxpi_top: per receive port event status and forward gpio status registers,
// reached through the hub's i2c register access port with a port select.
// assumes the i2c slave gives one-cycle read and write strobes on mclk_i.
`timescale 1ns/10ps
module rxpi_top
	import rxpi_pkg::*;
(
	// clock and reset
	input  wire logic                       mclk_i,
	input  wire logic                       reset_i,
	// register access
	input  wire logic [7:0]                 reg_addr_i,
	input  wire logic                       reg_wr_i,
	input  wire logic                       reg_rd_i,
	input  wire logic [7:0]                 reg_wdata_i,
	output logic      [7:0]                 reg_rdata_o,
	output logic                            reg_rvalid_o,
	// reads of the link status registers held elsewhere
	input  wire logic                       rx_status_one_read_i,
	input  wire logic                       rx_status_two_read_i,
	// link events per port
	input  wire logic [NPORT-1:0]           line_length_event_i,
	input  wire logic [NPORT-1:0]           line_count_event_i,
	input  wire logic [NPORT-1:0]           rx_overflow_event_i,
	input  wire logic [NPORT-1:0]           link_parity_event_i,
	input  wire logic [NPORT-1:0]           port_valid_i,
	input  wire logic [NPORT-1:0]           lock_i,
	input  wire logic [NPORT-1:0][NGPIO-1:0] fwd_gpio_i,
	// interrupt requests per port
	output logic      [NPORT-1:0]           port_irq_o
);
	logic [7:0]        psel_q,   psel_d;
	logic [7:0]        rdata_q,  rdata_d;
	logic              rvalid_q, rvalid_d;
	logic [PSEL_W-1:0] port;
	logic [7:0]        ev_sts  [NPORT];
	logic [7:0]        ev_en   [NPORT];
	logic [7:0]        gp_edge [NPORT];
	logic [3:0]        gp_evt  [NPORT];

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
		return addr == target;
	endfunction : hit

	assign port = psel_q[PSEL_W-1:0];

	for (genvar p = 0; p < NPORT; p++) begin : g_port
		logic mine;
		assign mine = (port == PSEL_W'(p));
		rxpi_port u_port (
			.mclk_i              (mclk_i),
			.reset_i             (reset_i),
			.line_length_event_i (line_length_event_i[p]),
			.line_count_event_i  (line_count_event_i[p]),
			.rx_overflow_event_i (rx_overflow_event_i[p]),
			.link_parity_event_i (link_parity_event_i[p]),
			.port_valid_i        (port_valid_i[p]),
			.lock_i              (lock_i[p]),
			.fwd_gpio_i          (fwd_gpio_i[p]),
			.sts_one_read_i      (mine & rx_status_one_read_i),
			.sts_two_read_i      (mine & rx_status_two_read_i),
			.gpio_sts_read_i     (mine & reg_rd_i & hit(reg_addr_i, ADDR_GPIO_STS)),
			.event_en_wr_i       (mine & reg_wr_i & hit(reg_addr_i, ADDR_EVENT_EN)),
			.gpio_edge_wr_i      (mine & reg_wr_i & hit(reg_addr_i, ADDR_GPIO_EDGE)),
			.wdata_i             (reg_wdata_i),
			.event_sts_o         (ev_sts[p]),
			.event_en_o          (ev_en[p]),
			.gpio_edge_o         (gp_edge[p]),
			.gpio_evt_o          (gp_evt[p]),
			.irq_o               (port_irq_o[p])
		);
	end

	always_comb begin
		psel_d   = psel_q;
		rdata_d  = rdata_q;
		rvalid_d = reg_rd_i;
		if (reg_wr_i && hit(reg_addr_i, ADDR_PORT_SEL)) begin
			psel_d = reg_wdata_i & MASK_PORT_SEL;
		end
		if (reg_rd_i) begin
			// edge enable is write-only, so it reads zero like an unmapped address
			unique case (reg_addr_i)
				ADDR_PORT_SEL:  rdata_d = psel_q;
				ADDR_EVENT_EN:  rdata_d = ev_en[port];
				ADDR_EVENT_STS: rdata_d = ev_sts[port];
				ADDR_GPIO_STS:  rdata_d = {gp_evt[port], fwd_gpio_i[port]};
				default:        rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			psel_q   <= RST_PORT_SEL;
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			psel_q   <= psel_d;
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign reg_rdata_o  = rdata_q;
	assign reg_rvalid_o = rvalid_q;

	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	property p_psel_route;
		reg_wr_i && hit(reg_addr_i, ADDR_EVENT_EN) && port == 2'h1
			|=> ev_en[1] == ($past(reg_wdata_i) & MASK_EVENTS) && $stable(ev_en[0]);
	endproperty
	a_psel_route: assert property (p_psel_route) else $error("enable write misrouted");

	property p_line_len;
		line_length_event_i[0] |=> ev_sts[0][BIT_LINE_LEN];
	endproperty
	a_line_len: assert property (p_line_len) else $error("line length event lost");

	property p_line_cnt_hold;
		ev_sts[2][BIT_LINE_CNT] && !(rx_status_two_read_i && port == 2'h2)
			|=> ev_sts[2][BIT_LINE_CNT];
	endproperty
	a_line_cnt_hold: assert property (p_line_cnt_hold) else $error("line count bit dropped");

	property p_ovf_clear;
		rx_status_two_read_i && port == 2'h3 && !rx_overflow_event_i[3]
			|=> !ev_sts[3][BIT_OVERFLOW];
	endproperty
	a_ovf_clear: assert property (p_ovf_clear) else $error("overflow bit not cleared");

	property p_parity_clear;
		rx_status_one_read_i && port == 2'h0 && !link_parity_event_i[0]
			|=> !ev_sts[0][BIT_PARITY];
	endproperty
	a_parity_clear: assert property (p_parity_clear) else $error("parity bit not cleared");

	property p_valid_change;
		$changed(port_valid_i[1]) && !$past(reset_i) |=> ev_sts[1][BIT_PORT_VALID];
	endproperty
	a_valid_change: assert property (p_valid_change) else $error("port valid change missed");

	property p_lock_change;
		$changed(lock_i[3]) && !$past(reset_i) |=> ev_sts[3][BIT_LOCK];
	endproperty
	a_lock_change: assert property (p_lock_change) else $error("lock change missed");

	// reserved bits checked where the host sees them, for whichever port is chosen
	property p_reserved_zero;
		reg_rd_i && hit(reg_addr_i, ADDR_EVENT_STS)
			|=> reg_rdata_o[7] == 1'b0 && reg_rdata_o[3] == 1'b0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bit set");

	property p_live_gpio;
		reg_rd_i && hit(reg_addr_i, ADDR_GPIO_STS)
			|=> reg_rvalid_o && reg_rdata_o[3:0] == $past(fwd_gpio_i[port]);
	endproperty
	a_live_gpio: assert property (p_live_gpio) else $error("gpio level readback wrong");

	property p_rvalid_timing;
		!$past(reset_i) |-> reg_rvalid_o == $past(reg_rd_i);
	endproperty
	a_rvalid_timing: assert property (p_rvalid_timing) else $error("read answer mistimed");

	property p_rise;
		gp_edge[0][0] && $rose(fwd_gpio_i[0][0]) && !$past(reset_i) |=> gp_evt[0][0];
	endproperty
	a_rise: assert property (p_rise) else $error("rising edge event missed");

	property p_rise_masked;
		!gp_edge[0][0] && $rose(fwd_gpio_i[0][0]) && !gp_evt[0][0] |=> !gp_evt[0][0];
	endproperty
	a_rise_masked: assert property (p_rise_masked) else $error("masked rise raised event");

	property p_fall;
		gp_edge[0][7] && $fell(fwd_gpio_i[0][3]) && !$past(reset_i) |=> gp_evt[0][3];
	endproperty
	a_fall: assert property (p_fall) else $error("falling edge event missed");

	property p_gpio_clear;
		reg_rd_i && hit(reg_addr_i, ADDR_GPIO_STS) && port == 2'h0 && $stable(fwd_gpio_i[0])
			|=> gp_evt[0] == 4'h0;
	endproperty
	a_gpio_clear: assert property (p_gpio_clear) else $error("gpio events not cleared");

	property p_irq_gate;
		port_irq_o[2] == |(ev_sts[2] & ev_en[2]);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq not gated by enable");

	property p_irq_event;
		line_length_event_i[2] && ev_en[2][BIT_LINE_LEN] && !reg_wr_i |=> port_irq_o[2];
	endproperty
	a_irq_event: assert property (p_irq_event) else $error("enabled event gave no irq");

	property p_set_wins;
		rx_status_one_read_i && port == 2'h0 && link_parity_event_i[0]
			|=> ev_sts[0][BIT_PARITY];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost at clear");

	c_irq:      cover property (port_irq_o[1] ##1 !port_irq_o[1]);
	c_gpio_evt: cover property (gp_evt[0] != 4'h0 ##[1:20] reg_rvalid_o);
	c_collide:  cover property (rx_status_two_read_i && line_length_event_i[port]);
	c_par_keep: cover property (rx_status_one_read_i && link_parity_event_i[port]);
	c_lock_irq: cover property (ev_sts[3][BIT_LOCK] && port_irq_o[3]);
endmodule : rxpi_top

// File: logic/rxpi_pkg.sv
// rxpi_pkg: offsets, field positions and reset values of the per-port
// event status block. assumes an 8-bit register space shared with the hub.
package rxpi_pkg;
	localparam int          NPORT           = 4;
	localparam int          NGPIO           = 4;
	localparam int          PSEL_W          = 2;
	// register offsets
	localparam logic [7:0]  ADDR_PORT_SEL   = 8'h4c;
	localparam logic [7:0]  ADDR_EVENT_EN   = 8'hd9;
	localparam logic [7:0]  ADDR_EVENT_STS  = 8'hdb;
	localparam logic [7:0]  ADDR_GPIO_STS   = 8'hdc;
	localparam logic [7:0]  ADDR_GPIO_EDGE  = 8'hdd;
	// event field positions
	localparam int          BIT_LINE_LEN    = 6;
	localparam int          BIT_LINE_CNT    = 5;
	localparam int          BIT_OVERFLOW    = 4;
	localparam int          BIT_PARITY      = 2;
	localparam int          BIT_PORT_VALID  = 1;
	localparam int          BIT_LOCK        = 0;
	localparam int          BIT_GPIO_EVT_LO = 4;
	localparam logic [7:0]  MASK_EVENTS     = 8'h77;
	localparam logic [7:0]  MASK_STS_ONE    = 8'h07;
	localparam logic [7:0]  MASK_STS_TWO    = 8'h70;
	localparam logic [7:0]  MASK_PORT_SEL   = 8'h03;
	// reset values
	localparam logic [7:0]  RST_EVENT_EN    = 8'h00;
	localparam logic [7:0]  RST_EVENT_STS   = 8'h00;
	localparam logic [7:0]  RST_GPIO_EDGE   = 8'h00;
	localparam logic [3:0]  RST_GPIO_EVT    = 4'h0;
	localparam logic [7:0]  RST_PORT_SEL    = 8'h00;
endpackage : rxpi_pkg

// File: logic/rxpi_port.sv
// rxpi_port: one receive port's event status, event enables and gpio edge logic.
// assumes events and gpio levels are synchronous to mclk_i.
`timescale 1ns/10ps
module rxpi_port
	import rxpi_pkg::*;
(
	// clock and reset
	input  wire logic             mclk_i,
	input  wire logic             reset_i,
	// link events and levels
	input  wire logic             line_length_event_i,
	input  wire logic             line_count_event_i,
	input  wire logic             rx_overflow_event_i,
	input  wire logic             link_parity_event_i,
	input  wire logic             port_valid_i,
	input  wire logic             lock_i,
	input  wire logic [NGPIO-1:0] fwd_gpio_i,
	// register side, already qualified by port select
	input  wire logic             sts_one_read_i,
	input  wire logic             sts_two_read_i,
	input  wire logic             gpio_sts_read_i,
	input  wire logic             event_en_wr_i,
	input  wire logic             gpio_edge_wr_i,
	input  wire logic [7:0]       wdata_i,
	// state
	output logic      [7:0]       event_sts_o,
	output logic      [7:0]       event_en_o,
	output logic      [7:0]       gpio_edge_o,
	output logic      [3:0]       gpio_evt_o,
	output logic                  irq_o
);
	logic [7:0]       ev_q,     ev_d;
	logic [7:0]       en_q,     en_d;
	logic [7:0]       edge_q,   edge_d;
	logic [3:0]       gev_q,    gev_d;
	logic [NGPIO-1:0] gprev_q,  gprev_d;
	logic             vprev_q,  vprev_d;
	logic             lprev_q,  lprev_d;
	logic             armed_q,  armed_d;
	logic [7:0]       ev_set;
	logic [7:0]       ev_clr;

	// edge hits of the gpio levels against their enables
	function automatic logic [3:0] edge_hits(input logic [3:0] prev, input logic [3:0] cur,
	                                         input logic [7:0] en);
		logic [3:0] h;
		h = 4'h0;
		for (int i = 0; i < NGPIO; i++) begin
			h[i] = (en[2*i] & ~prev[i] & cur[i]) | (en[2*i+1] & prev[i] & ~cur[i]);
		end
		return h;
	endfunction : edge_hits

	always_comb begin
		ev_set                 = 8'h00;
		ev_set[BIT_LINE_LEN]   = line_length_event_i;
		ev_set[BIT_LINE_CNT]   = line_count_event_i;
		ev_set[BIT_OVERFLOW]   = rx_overflow_event_i;
		ev_set[BIT_PARITY]     = link_parity_event_i;
		// first cycle after reset has no valid history, so no change is claimed
		ev_set[BIT_PORT_VALID] = armed_q & (port_valid_i ^ vprev_q);
		ev_set[BIT_LOCK]       = armed_q & (lock_i ^ lprev_q);
		ev_clr = ({8{sts_one_read_i}} & MASK_STS_ONE) | ({8{sts_two_read_i}} & MASK_STS_TWO);
		// set wins over the clearing read
		ev_d   = ((ev_q & ~ev_clr) | ev_set) & MASK_EVENTS;
		en_d   = event_en_wr_i ? (wdata_i & MASK_EVENTS) : en_q;
		edge_d = gpio_edge_wr_i ? wdata_i : edge_q;
		gev_d  = (gev_q & ~{4{gpio_sts_read_i}}) |
		         (armed_q ? edge_hits(gprev_q, fwd_gpio_i, edge_q) : 4'h0);
		gprev_d = fwd_gpio_i;
		vprev_d = port_valid_i;
		lprev_d = lock_i;
		armed_d = 1'b1;
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			ev_q    <= RST_EVENT_STS;
			en_q    <= RST_EVENT_EN;
			edge_q  <= RST_GPIO_EDGE;
			gev_q   <= RST_GPIO_EVT;
			gprev_q <= '0;
			vprev_q <= 1'b0;
			lprev_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			ev_q    <= ev_d;
			en_q    <= en_d;
			edge_q  <= edge_d;
			gev_q   <= gev_d;
			gprev_q <= gprev_d;
			vprev_q <= vprev_d;
			lprev_q <= lprev_d;
			armed_q <= armed_d;
		end
	end

	assign event_sts_o = ev_q;
	assign event_en_o  = en_q;
	assign gpio_edge_o = edge_q;
	assign gpio_evt_o  = gev_q;
	assign irq_o       = |(ev_q & en_q);
endmodule : rxpi_port

// File: tb/rxpi_host.sv
// rxpi_host: register-access host model driving one-cycle byte strobes.
// assumes read data and rvalid arrive one cycle after the read strobe.
`timescale 1ns/10ps
module rxpi_host (
	// clock
	input  wire logic       mclk_i,
	// register access
	output logic      [7:0] reg_addr_o,
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	output logic      [7:0] reg_wdata_o,
	input  wire logic [7:0] reg_rdata_i,
	input  wire logic       reg_rvalid_i
);
	initial begin
		reg_addr_o  = 8'h00;
		reg_wr_o    = 1'b0;
		reg_rd_o    = 1'b0;
		reg_wdata_o = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		#1;
		reg_addr_o  = a;
		reg_wdata_o = d;
		reg_wr_o    = 1'b1;
		@(posedge mclk_i);
		#1;
		reg_wr_o    = 1'b0;
		reg_wdata_o = ~d;  // stale data must not look valid
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge mclk_i);
		#1;
		reg_addr_o = a;
		reg_rd_o   = 1'b1;
		@(posedge mclk_i);
		#1;
		reg_rd_o   = 1'b0;
		reg_addr_o = ~a;
		d          = reg_rdata_i;
		v          = reg_rvalid_i;
	endtask : rd
endmodule : rxpi_host

// File: tb/testbench.sv
// testbench: random and directed checks of the per-port event status block.
// assumes the host model's one-cycle strobes and a 10 MHz mclk_i.
`timescale 1ns/10ps
module testbench;
	import rxpi_pkg::*;
	logic                        mclk_i  = 1'b0;
	logic                        reset_i = 1'b1;
	logic [7:0]                  reg_addr, reg_wdata, reg_rdata;
	logic                        reg_wr, reg_rd, reg_rvalid;
	logic                        sts1_rd = 1'b0, sts2_rd = 1'b0;
	logic [NPORT-1:0]            len_ev = '0, cnt_ev = '0, ovf_ev = '0, par_ev = '0;
	logic [NPORT-1:0]            pvalid = '0, lock = '0, irq;
	logic [NPORT-1:0][NGPIO-1:0] gpio = '0;
	logic [15:0]                 lfsr = 16'd20436;
	int                          failures = 0, checked = 0, cycles = 0;
	localparam int               ev_bit [6] = '{BIT_LINE_LEN, BIT_LINE_CNT, BIT_OVERFLOW,
		BIT_PARITY, BIT_PORT_VALID, BIT_LOCK};
	localparam logic [7:0]       addr_tab [7] = '{ADDR_PORT_SEL, ADDR_EVENT_EN, ADDR_EVENT_STS,
		ADDR_GPIO_STS, ADDR_GPIO_EDGE, 8'h00, 8'hff};

	always #50 mclk_i = ~mclk_i;

	rxpi_host host_u (.mclk_i(mclk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
		.reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata),
		.reg_rvalid_i(reg_rvalid));
	rxpi_top dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .reg_addr_i(reg_addr),
		.reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata),
		.reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
		.rx_status_one_read_i(sts1_rd), .rx_status_two_read_i(sts2_rd),
		.line_length_event_i(len_ev), .line_count_event_i(cnt_ev),
		.rx_overflow_event_i(ovf_ev), .link_parity_event_i(par_ev),
		.port_valid_i(pvalid), .lock_i(lock), .fwd_gpio_i(gpio), .port_irq_o(irq));

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next
	// expected gpio events: rise on even enable bit, fall on odd one
	function automatic logic [3:0] gpio_exp(input logic [3:0] o, n, input logic [7:0] e);
		logic [3:0] r;
		for (int g = 0; g < 4; g++) begin
			r[g] = (n[g] & ~o[g] & e[2*g]) | (~n[g] & o[g] & e[2*g+1]);
		end
		return r;
	endfunction : gpio_exp
	task automatic rnd(output logic [7:0] v);
		lfsr = lfsr_next(lfsr);
		v    = lfsr[7:0];
	endtask : rnd
	task automatic chk(input logic [7:0] got, exp, input string what);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic rdchk(input logic [7:0] a, exp, input string what);
		logic [7:0] d;
		logic       v;
		host_u.rd(a, d, v);
		chk({7'h00, v}, 8'h01, "rvalid");
		chk(d, exp, what);
	endtask : rdchk
	// one link event on port p; levels toggle, pulses last one cycle
	task automatic ev(input int p, k);
		@(posedge mclk_i);
		#1;
		case (k)
			0: len_ev[p] = 1'b1;
			1: cnt_ev[p] = 1'b1;
			2: ovf_ev[p] = 1'b1;
			3: par_ev[p] = 1'b1;
			4: pvalid[p] = ~pvalid[p];
			default: lock[p] = ~lock[p];
		endcase
		@(posedge mclk_i);
		#1;
		{len_ev, cnt_ev, ovf_ev, par_ev} = '0;
	endtask : ev
	task automatic sread(input logic two);
		@(posedge mclk_i);
		#1;
		{sts2_rd, sts1_rd} = two ? 2'b10 : 2'b01;
		@(posedge mclk_i);
		#1;
		{sts2_rd, sts1_rd} = 2'b00;
	endtask : sread
	task automatic test_done();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done

	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("unexpected at %0t: run too long", $time);
			test_done();
		end
	end

	initial begin
		logic [7:0] e, d;
		logic [3:0] o, n;
		repeat (5) @(posedge mclk_i);
		#1 reset_i = 1'b0;
		for (int i = 0; i < 7; i++) rdchk(addr_tab[i], 8'h00, "reset value");
		for (int p = 0; p < NPORT; p++) begin
			host_u.wr(ADDR_PORT_SEL, 8'(p) | 8'hfc);
			rdchk(ADDR_PORT_SEL, 8'(p), "port select");
			rnd(e);
			host_u.wr(ADDR_EVENT_EN, e);
			rdchk(ADDR_EVENT_EN, e & MASK_EVENTS, "enable");
			for (int k = 0; k < 6; k++) begin
				ev(p, k);
				rdchk(ADDR_EVENT_STS, 8'h01 << ev_bit[k], "event set");
				chk({4'h0, irq}, {4'h0, e[ev_bit[k]] ? 4'(1 << p) : 4'h0}, "irq");
				sread(k > 2);
				rdchk(ADDR_EVENT_STS, 8'h01 << ev_bit[k], "wrong clear");
				sread(k < 3);
				rdchk(ADDR_EVENT_STS, 8'h00, "event clear");
			end
			fork
				ev(p, 0);
				sread(1'b1);
			join
			rdchk(ADDR_EVENT_STS, 8'h40, "event kept");
			sread(1'b1);
			fork
				ev(p, 3);
				sread(1'b0);
			join
			rdchk(ADDR_EVENT_STS, 8'h04, "parity kept");
			sread(1'b0);
			rdchk(ADDR_EVENT_STS, 8'h00, "parity clear");
			rnd(e);
			host_u.wr(ADDR_GPIO_EDGE, e);
			rdchk(ADDR_GPIO_EDGE, 8'h00, "edge enable write-only");
			for (int j = 0; j < 8; j++) begin
				o = gpio[p];
				rnd(d);
				n = (j == 0) ? ~o : d[3:0];
				@(posedge mclk_i);
				#1 gpio[p] = n;
				rdchk(ADDR_GPIO_STS, {gpio_exp(o, n, e), n}, "gpio edge");
				rdchk(ADDR_GPIO_STS, {4'h0, n}, "gpio clear");
			end
			host_u.wr(ADDR_GPIO_STS, 8'hff);
			o = gpio[p];
			n = ~o;
			fork
				rdchk(ADDR_GPIO_STS, {4'h0, n}, "gpio live");
				begin
					@(posedge mclk_i);
					#1 gpio[p] = n;
				end
			join
			rdchk(ADDR_GPIO_STS, {gpio_exp(o, n, e), n}, "gpio kept");
		end
		test_done();
	end
endmodule : testbench
